// File: logic/hard_timer_counter_pwm.sv
`timescale 1ns/1ps

// What this block does
// - Sixteen-bit counter counting up or down with compare and PWM output.
// - Four modes: watchdog, clear on match, fast PWM, phase-frequency PWM.
// - Count clock chosen from system clock or pin, then prescaled.
// - Overflow, compare and capture events merge onto one interrupt output.
// - A separate wake-up pulse goes to the standby controller.
// - Bus attached: masked flags drive interrupt; else it shows overflow.
// - Capture pin rising edge stores the count in non-PWM modes, only while bus attached.
// - Counter reloads itself at every period end.
// - PWM period and duty change only at period ends or on the direct reset pin, never glitching.
// - Compare wave output is driven by mode and compare logic.
// - Control and status reach fabric logic through the configuration port.
// - Block runs stand-alone from preset configuration and a reset pin.
// - Direct active-low reset pin stays enabled by a preset setting.
module hard_timer_counter_pwm
    import timer_pkg::*;
#(
    parameter bit DIRECT_RESET_ENABLE = 1'b1
)
(
    input  wire logic                   CLK,
    input  wire logic                   RST,
    input  cfg_type                     CFG,
    input  wire logic                   BUS_MODE,
    input  irq_type                     IRQ_CLEAR,
    input  wire logic                   WATCHDOG_KICK,
    input  wire logic                   COUNT_CLOCK_IN,
    input  wire logic                   DIRECT_RESET_N,
    input  wire logic                   CAPTURE_TRIGGER_IN,
    output logic                        COUNTER_IRQ_OUT,
    output logic                        WAKE_OUT,
    output logic                        COMPARE_WAVE_OUT,
    output logic [COUNT_WIDTH-1:0]      COUNT_VALUE,
    output logic [COUNT_WIDTH-1:0]      CAPTURE_HOLDING_REG,
    output irq_type                     IRQ_STATUS
);

    logic [SYNC_BITS-1:0]   sync1_ff;
    logic [SYNC_BITS-1:0]   sync2_ff;
    logic [SYNC_BITS-1:0]   sync3_ff;
    logic [SYNC_BITS-1:0]   level_ff;
    logic [SYNC_BITS-1:0]   prev_ff;
    logic [SYNC_BITS-1:0]   nxt_level;
    logic [COUNT_WIDTH-1:0] count_ff;
    logic [COUNT_WIDTH-1:0] nxt_count;
    logic [COUNT_WIDTH-1:0] top_ff;
    logic [COUNT_WIDTH-1:0] cmp_ff;
    logic [COUNT_WIDTH-1:0] capture_ff;
    logic                   down_ff;
    logic                   nxt_down;
    logic                   wave_ff;
    logic                   nxt_wave;
    logic                   irq_ff;
    logic                   wake_ff;
    irq_type                flags_ff;
    irq_type                nxt_flags;
    irq_type                events;
    irq_type                clear_mask;
    logic                   tick;
    logic                   reload;

    // A pin change counts once the second and third stages agree.
    assign nxt_level = (sync2_ff & ~(sync2_ff ^ sync3_ff))
                     | (level_ff & (sync2_ff ^ sync3_ff));

    wire [SYNC_BITS-1:0] pin_rise = level_ff & ~prev_ff;

    wire pin_reset  = DIRECT_RESET_ENABLE && !level_ff[PIN_RST];
    wire is_wdog    = CFG.mode == MODE_WATCHDOG;
    wire is_ctc     = CFG.mode == MODE_CLEAR_ON_MATCH;
    wire is_fast    = CFG.mode == MODE_FAST_PWM;
    wire is_pfc     = CFG.mode == MODE_PHASE_FREQ_PWM;
    wire is_pwm     = is_fast | is_pfc;

    wire src_pulse  = (CFG.clk_src == SRC_SYSTEM)
                    | ((CFG.clk_src == SRC_PIN) & pin_rise[PIN_CLK]);

    count_prescaler u_prescaler
    (
        .clk       (CLK),
        .rst       (RST),
        .src_pulse (src_pulse),
        .presc_sel (CFG.presc_sel),
        .tick      (tick)
    );

    // In clear-on-match mode the compare value itself ends the period.
    wire [COUNT_WIDTH-1:0] top_eff = is_ctc ? cmp_ff : top_ff;
    wire at_top    = count_ff == top_eff;
    wire at_bottom = count_ff == COUNT_ZERO;
    wire kick      = is_wdog & WATCHDOG_KICK;

    // Period end: the top for up-only modes, the bottom for the
    // dual-slope mode so both halves of a PWM cycle use one setting.
    wire period_end = tick & (is_pfc ? (down_ff & at_bottom) : at_top);

    assign reload = pin_reset | period_end;

    // Counter walk for each mode.
    always_comb
    begin
        nxt_count = count_ff;
        nxt_down  = down_ff;
        if (pin_reset || kick)
        begin
            nxt_count = COUNT_ZERO;
            nxt_down  = 1'b0;
        end
        else if (tick)
        begin
            case (CFG.mode)
                MODE_PHASE_FREQ_PWM:
                begin
                    if (!down_ff && at_top)
                    begin
                        nxt_down  = 1'b1;
                        nxt_count = at_bottom ? count_ff : count_ff - COUNT_ONE;
                    end
                    else if (down_ff && at_bottom)
                    begin
                        nxt_down  = 1'b0;
                        nxt_count = (CFG.top == COUNT_ZERO) ? COUNT_ZERO
                                                            : COUNT_ONE;
                    end
                    else
                        nxt_count = down_ff ? count_ff - COUNT_ONE
                                            : count_ff + COUNT_ONE;
                end
                MODE_WATCHDOG, MODE_CLEAR_ON_MATCH, MODE_FAST_PWM:
                begin
                    nxt_down  = 1'b0;
                    nxt_count = at_top ? COUNT_ZERO
                                       : count_ff + COUNT_ONE;
                end
                default:
                begin
                    nxt_down  = 1'b0;
                    nxt_count = count_ff;
                end
            endcase
        end
    end

    // Event sources and their sticky flags.
    assign events.overflow = period_end;
    assign events.compare  = tick & (count_ff == cmp_ff);
    assign events.capture  = BUS_MODE & CFG.capture_en & ~is_pwm
                           & pin_rise[PIN_CAP];

    // Only a bus master can clear flags; alone, the reset pin does.
    assign clear_mask = BUS_MODE ? IRQ_CLEAR : 3'h0;
    // A new event beats a clear that lands in the same cycle.
    assign nxt_flags  = pin_reset ? 3'h0
                      : ((flags_ff & ~clear_mask) | events);

    // Output wave per mode.
    always_comb
    begin
        nxt_wave = wave_ff;
        case (CFG.mode)
            MODE_FAST_PWM, MODE_PHASE_FREQ_PWM:
                nxt_wave = count_ff < cmp_ff;
            MODE_CLEAR_ON_MATCH:
                nxt_wave = events.compare ? ~wave_ff : wave_ff;
            MODE_WATCHDOG:
                nxt_wave = kick ? 1'b0 : (wave_ff | period_end);
            default:
                nxt_wave = 1'b0;
        endcase
        if (pin_reset)
            nxt_wave = 1'b0;
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            sync1_ff <= SYNC_RESET_VALUE;
            sync2_ff <= SYNC_RESET_VALUE;
            sync3_ff <= SYNC_RESET_VALUE;
            level_ff <= SYNC_RESET_VALUE;
            prev_ff  <= SYNC_RESET_VALUE;
        end
        else
        begin
            sync1_ff <= {CAPTURE_TRIGGER_IN, DIRECT_RESET_N, COUNT_CLOCK_IN};
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            level_ff <= nxt_level;
            prev_ff  <= level_ff;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            count_ff <= COUNT_ZERO;
            down_ff  <= 1'b0;
            top_ff   <= COUNT_ZERO;
            cmp_ff   <= COUNT_ZERO;
            wave_ff  <= 1'b0;
        end
        else
        begin
            count_ff <= nxt_count;
            down_ff  <= nxt_down;
            wave_ff  <= nxt_wave;
            if (reload)
            begin
                top_ff <= CFG.top;
                cmp_ff <= CFG.compare;
            end
        end
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            capture_ff <= COUNT_ZERO;
            flags_ff   <= 3'h0;
            irq_ff     <= 1'b0;
            wake_ff    <= 1'b0;
        end
        else
        begin
            if (events.capture)
                capture_ff <= count_ff;
            flags_ff <= nxt_flags;
            irq_ff   <= BUS_MODE ? |(flags_ff & CFG.irq_enable)
                                 : flags_ff.overflow;
            wake_ff  <= CFG.wake_enable & |events;
        end
    end

    assign COUNTER_IRQ_OUT     = irq_ff;
    assign WAKE_OUT            = wake_ff;
    assign COMPARE_WAVE_OUT    = wave_ff;
    assign COUNT_VALUE         = count_ff;
    assign CAPTURE_HOLDING_REG = capture_ff;
    assign IRQ_STATUS          = flags_ff;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    // The reset pin wins over a period end that lands in its first cycle.
    a_ovf_set: assert property (events.overflow && !pin_reset
        |=> flags_ff.overflow)
        else $error("overflow event did not set its flag");

    a_ovf_hold: assert property (flags_ff.overflow
        && !clear_mask.overflow && !pin_reset |=> flags_ff.overflow)
        else $error("overflow flag dropped without a clear");

    a_irq_alone: assert property (!BUS_MODE && $stable(BUS_MODE)
        && flags_ff.overflow ##1 !BUS_MODE |-> COUNTER_IRQ_OUT)
        else $error("stand-alone interrupt does not follow overflow");

    a_irq_capture: assert property (events.capture
        && CFG.irq_enable.capture && !pin_reset
        ##1 BUS_MODE && CFG.irq_enable.capture
        |=> COUNTER_IRQ_OUT)
        else $error("enabled capture did not raise the interrupt");

    a_capture_stamp: assert property (events.capture
        |=> CAPTURE_HOLDING_REG == $past(count_ff))
        else $error("capture register missed the count");

    a_capture_pwm: assert property (is_pwm && $stable(CFG.mode)
        |=> $stable(CAPTURE_HOLDING_REG))
        else $error("capture happened in a PWM mode");

    a_fast_reload: assert property (is_fast && tick && at_top
        && !pin_reset
        |=> count_ff == COUNT_ZERO && top_ff == $past(CFG.top))
        else $error("fast PWM did not reload at the top");

    a_pfc_turn: assert property (is_pfc && tick && down_ff
        && at_bottom && !pin_reset && $past(is_pfc) |=> !down_ff)
        else $error("dual-slope counter did not turn at bottom");

    a_shadow_hold: assert property (!reload
        |=> $stable(cmp_ff) && $stable(top_ff))
        else $error("PWM settings changed inside a period");

    a_reset_pin: assert property (pin_reset
        |=> count_ff == COUNT_ZERO && !COMPARE_WAVE_OUT
            && flags_ff == 3'h0)
        else $error("direct reset pin had no effect");

    a_wake_pulse: assert property (CFG.wake_enable
        && events.overflow |=> WAKE_OUT)
        else $error("wake pulse missing after overflow");

    c_fast_period: cover property (is_fast && period_end);
    c_pfc_turn: cover property (is_pfc && tick && !down_ff && at_top);
    c_capture: cover property (events.capture);
    c_ctc_toggle: cover property (is_ctc && events.compare);

endmodule // hard_timer_counter_pwm

// File: inc/timer_pkg.sv
package timer_pkg;

    localparam int COUNT_WIDTH = 16;
    localparam int PRESC_WIDTH = 10;
    localparam int SYNC_BITS   = 3;

    // Bit positions inside the synchronised pin vector.
    localparam int PIN_CLK = 0;
    localparam int PIN_RST = 1;
    localparam int PIN_CAP = 2;

    // The reset pin idles high, so its synchroniser starts high.
    localparam logic [SYNC_BITS-1:0] SYNC_RESET_VALUE = 3'h2;

    localparam logic [COUNT_WIDTH-1:0] COUNT_ZERO = 16'h0000;
    localparam logic [COUNT_WIDTH-1:0] COUNT_ONE  = 16'h0001;

    // Prescaler division as a power of two, one entry per select code 0 to 4; codes 5 to 7 divide by one.
    localparam logic [3:0] PRESC_LOG_1    = 4'h0;
    localparam logic [3:0] PRESC_LOG_8    = 4'h3;
    localparam logic [3:0] PRESC_LOG_64   = 4'h6;
    localparam logic [3:0] PRESC_LOG_256  = 4'h8;
    localparam logic [3:0] PRESC_LOG_1024 = 4'hA;

    typedef enum logic [3:0]
    {
        MODE_WATCHDOG = 4'h1,
        MODE_CLEAR_ON_MATCH = 4'h2,
        MODE_FAST_PWM = 4'h4,
        MODE_PHASE_FREQ_PWM = 4'h8
    } mode_type;

    typedef enum logic [1:0]
    {
        SRC_STOPPED = 2'h0,
        SRC_SYSTEM = 2'h1,
        SRC_PIN = 2'h2
    } clk_src_type;

    typedef struct packed
    {
        logic capture;
        logic compare;
        logic overflow;
    } irq_type;

    typedef struct packed
    {
        mode_type                mode;
        clk_src_type             clk_src;
        logic [2:0]              presc_sel;
        logic [COUNT_WIDTH-1:0]  top;
        logic [COUNT_WIDTH-1:0]  compare;
        logic                    capture_en;
        irq_type                 irq_enable;
        logic                    wake_enable;
    } cfg_type;

    function automatic logic [PRESC_WIDTH-1:0] presc_mask
    (
        input logic [2:0] sel
    );
        logic [3:0] lg;
        lg = PRESC_LOG_1;
        case (sel)
            3'h1:    lg = PRESC_LOG_8;
            3'h2:    lg = PRESC_LOG_64;
            3'h3:    lg = PRESC_LOG_256;
            3'h4:    lg = PRESC_LOG_1024;
            default: lg = PRESC_LOG_1;
        endcase
        presc_mask = PRESC_WIDTH'((11'h001 << lg) - 11'h001);
    endfunction

endpackage

// File: logic/count_prescaler.sv
`timescale 1ns/1ps

module count_prescaler
    import timer_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       src_pulse,
    input  wire logic [2:0] presc_sel,
    output logic            tick
);

    logic [PRESC_WIDTH-1:0] div_ff;
    logic [PRESC_WIDTH-1:0] nxt_div;
    wire  [PRESC_WIDTH-1:0] mask = presc_mask(presc_sel);
    wire                    wrap = (div_ff & mask) == mask;

    // Only the bits under the mask matter, so a new select takes
    // effect within one short period instead of a full 1024 wait.
    assign tick    = src_pulse & wrap;
    assign nxt_div = tick ? '0 : (src_pulse ? div_ff + 1'b1 : div_ff);

    always_ff @(posedge clk)
    begin
        if (rst)
            div_ff <= '0;
        else
            div_ff <= nxt_div;
    end

    a_presc_bypass: assert property (@(posedge clk) disable iff (rst)
        presc_sel == 3'h0 |-> tick == src_pulse)
        else $error("prescaler bypass does not pass every pulse");

    // After a tick at divide by eight, seven quiet cycles must follow.
    a_presc_div8: assert property (@(posedge clk) disable iff (rst)
        tick && presc_sel == 3'h1
        |=> (!tick || presc_sel != 3'h1) [*7])
        else $error("prescaler divide by eight misbehaves");

endmodule // count_prescaler

// File: testbench/pin_source.sv
`timescale 1ns/1ps

// Drives the count clock, reset and capture pins as slow levels, so that
// the three-flop synchronisers inside the block see every change.
module pin_source
(
    input  wire logic clk,
    output logic      clk_pin,
    output logic      rst_pin_n,
    output logic      cap_pin
);
    initial
    begin
        clk_pin   = 1'b0;
        rst_pin_n = 1'b1;
        cap_pin   = 1'b0;
    end

    task automatic hold(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic clock_pulses(input int n);
        repeat (n)
        begin
            clk_pin <= 1'b1;
            hold(4);
            clk_pin <= 1'b0;
            hold(6);
        end
    endtask

    task automatic drive_reset(input logic v);
        rst_pin_n <= v;
    endtask

    task automatic capture_rise();
        cap_pin <= 1'b1;
        hold(8);
        cap_pin <= 1'b0;
        hold(4);
    endtask
endmodule // pin_source

// File: testbench/tb.sv
`timescale 1ns/1ps

module tb;
    import timer_pkg::*;

    localparam int LIMIT = 20000;

    logic                   CLK;
    logic                   RST;
    cfg_type                CFG;
    logic                   BUS_MODE;
    irq_type                IRQ_CLEAR;
    logic                   WATCHDOG_KICK;
    logic                   clk_pin;
    logic                   rst_pin_n;
    logic                   cap_pin;
    logic                   irq_out;
    logic                   wake;
    logic                   wave;
    logic [COUNT_WIDTH-1:0] count;
    logic [COUNT_WIDTH-1:0] held;
    irq_type                status;
    int                     error_cnt;
    int                     n_compared;
    int                     cycles;
    logic [COUNT_WIDTH-1:0] exp_q[$];
    int                     div_tbl[6] = '{1, 8, 64, 256, 1024, 1};

    hard_timer_counter_pwm u_dut
    (
        .CLK                (CLK),
        .RST                (RST),
        .CFG                (CFG),
        .BUS_MODE           (BUS_MODE),
        .IRQ_CLEAR          (IRQ_CLEAR),
        .WATCHDOG_KICK      (WATCHDOG_KICK),
        .COUNT_CLOCK_IN     (clk_pin),
        .DIRECT_RESET_N     (rst_pin_n),
        .CAPTURE_TRIGGER_IN (cap_pin),
        .COUNTER_IRQ_OUT    (irq_out),
        .WAKE_OUT           (wake),
        .COMPARE_WAVE_OUT   (wave),
        .COUNT_VALUE        (count),
        .CAPTURE_HOLDING_REG(held),
        .IRQ_STATUS         (status)
    );

    pin_source u_pins
    (
        .clk      (CLK),
        .clk_pin  (clk_pin),
        .rst_pin_n(rst_pin_n),
        .cap_pin  (cap_pin)
    );

    initial
    begin
        CLK = 1'b0;
        forever #2.5 CLK = ~CLK;
    end

    always @(posedge CLK)
    begin
        cycles <= cycles + 1;
        if (cycles == LIMIT)
        begin
            error_cnt = error_cnt + 1;
            results();
        end
    end

    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge CLK);
    endtask

    task automatic chk(input string name, input logic [15:0] e,
                       input logic [15:0] g);
        n_compared = n_compared + 1;
        if (g !== e)
        begin
            error_cnt = error_cnt + 1;
            $display("[ERR] %s expected %h seen %h", name, e, g);
        end
    endtask

    // The direct reset pin also loads the period shadows, so every
    // scenario starts from a known phase with its own top and compare.
    task automatic restart(input mode_type m, input clk_src_type s,
                           input logic [15:0] t, input logic [15:0] c);
        CFG.mode <= m;
        CFG.clk_src <= s;
        CFG.top <= t;
        CFG.compare <= c;
        u_pins.drive_reset(1'b0);
        step(8);
        @(negedge CLK);
        chk("count in reset", 16'h0000, count);
        @(posedge CLK);
        u_pins.drive_reset(1'b1);
        step(6);
    endtask

    task automatic check_seq(input string name, input logic [15:0] s);
        int i;
        i = 0;
        @(negedge CLK);
        while (count !== s && i < 3000)
        begin
            @(negedge CLK);
            i++;
        end
        foreach (exp_q[k])
        begin
            @(negedge CLK);
            chk(name, exp_q[k], count);
        end
        exp_q.delete();
        @(posedge CLK);
    endtask

    task automatic high_cnt(input string name, input bit w, input int e);
        int h;
        h = 0;
        repeat (12)
        begin
            @(negedge CLK);
            if ((w ? wave : wake) === 1'b1)
                h++;
        end
        chk(name, e[15:0], h[15:0]);
        @(posedge CLK);
    endtask

    task automatic wait_change(output int n);
        logic [COUNT_WIDTH-1:0] v;
        v = count;
        n = 0;
        while (count === v && n < 2100)
        begin
            @(negedge CLK);
            n++;
        end
    endtask

    task automatic interval(input logic [2:0] sel, input int e);
        int n;
        CFG.presc_sel <= sel;
        restart(MODE_CLEAR_ON_MATCH, SRC_SYSTEM, 16'hFFFF, 16'hFFFF);
        @(negedge CLK);
        wait_change(n);
        wait_change(n);
        chk("prescaler period", e[15:0], n[15:0]);
        @(posedge CLK);
    endtask

    task automatic pulse_clear(input irq_type c);
        IRQ_CLEAR <= c;
        step(1);
        IRQ_CLEAR <= 3'h0;
        step(3);
        @(negedge CLK);
    endtask

    initial
    begin
        RST = 1'b1;
        CFG = '0;
        CFG.wake_enable = 1'b1;
        BUS_MODE = 1'b0;
        IRQ_CLEAR = 3'h0;
        WATCHDOG_KICK = 1'b0;
        error_cnt = 0;
        n_compared = 0;
        cycles = 0;
        step(12);
        RST <= 1'b0;
        @(negedge CLK);
        chk("count after reset", 16'h0000, count);
        @(posedge CLK);
        for (int i = 0; i < 6; i++)
            interval(3'(i), div_tbl[i]);
        $display("done: prescaler");
        restart(MODE_FAST_PWM, SRC_SYSTEM, 16'h0002, 16'h0001);
        exp_q = '{16'h0000, 16'h0001, 16'h0002, 16'h0000};
        check_seq("fast pwm count", 16'h0002);
        high_cnt("fast pwm wave", 1'b1, 4);
        high_cnt("wake pulses", 1'b0, 8);
        check_seq("sync", 16'h0000);
        CFG.top <= 16'h0004;
        exp_q = '{16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h0004};
        check_seq("period change", 16'h0002);
        $display("done: fast pwm");
        // Stopping the count clock keeps new events from hiding a clear.
        CFG.clk_src <= SRC_STOPPED;
        pulse_clear(3'h1);
        chk("standalone irq", 1'b1, irq_out);
        chk("standalone flag", 1'b1, status.overflow);
        chk("compare flag", 1'b1, status.compare);
        @(posedge CLK);
        BUS_MODE <= 1'b1;
        step(3);
        @(negedge CLK);
        chk("masked irq", 1'b0, irq_out);
        @(posedge CLK);
        CFG.irq_enable <= 3'h3;
        pulse_clear(3'h1);
        chk("overflow cleared", 1'b0, status.overflow);
        chk("compare irq", 1'b1, irq_out);
        @(posedge CLK);
        pulse_clear(3'h2);
        chk("irq after clear", 1'b0, irq_out);
        @(posedge CLK);
        $display("done: interrupts");
        restart(MODE_PHASE_FREQ_PWM, SRC_SYSTEM, 16'h0003, 16'h0002);
        exp_q = '{16'h0002, 16'h0001, 16'h0000, 16'h0001, 16'h0002};
        check_seq("dual slope count", 16'h0003);
        high_cnt("dual slope wave", 1'b1, 6);
        $display("done: dual slope");
        restart(MODE_CLEAR_ON_MATCH, SRC_SYSTEM, 16'hFFFF, 16'h0005);
        exp_q = '{16'h0000, 16'h0001};
        check_seq("clear on match", 16'h0005);
        high_cnt("toggle wave", 1'b1, 6);
        $display("done: clear on match");
        restart(MODE_WATCHDOG, SRC_SYSTEM, 16'h0004, 16'hFFFF);
        step(10);
        @(negedge CLK);
        chk("watchdog timeout", 1'b1, wave);
        @(posedge CLK);
        WATCHDOG_KICK <= 1'b1;
        step(1);
        WATCHDOG_KICK <= 1'b0;
        step(1);
        @(negedge CLK);
        chk("watchdog kick", 1'b0, wave);
        @(posedge CLK);
        $display("done: watchdog");
        CFG.capture_en <= 1'b1;
        CFG.irq_enable <= 3'h7;
        restart(MODE_CLEAR_ON_MATCH, SRC_PIN, 16'hFFFF, 16'hFFFF);
        u_pins.clock_pulses(5);
        @(negedge CLK);
        chk("pin count", 16'h0005, count);
        chk("irq before capture", 1'b0, irq_out);
        @(posedge CLK);
        u_pins.capture_rise();
        @(negedge CLK);
        chk("capture value", 16'h0005, held);
        chk("capture flag", 1'b1, status.capture);
        chk("capture irq", 1'b1, irq_out);
        @(posedge CLK);
        CFG.mode <= MODE_FAST_PWM;
        u_pins.clock_pulses(2);
        u_pins.capture_rise();
        @(negedge CLK);
        chk("no capture in pwm", 16'h0005, held);
        $display("done: capture");
        results();
    end
endmodule // tb
